// ---- inc/qsj_pkg.sv ----
/*
  constants, field layouts and state encodings for the four-channel slope
  converter controller.
  assumes: registers are addressed by word index taken from address lines 5:2.
*/
package qsj_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 4;
  localparam int CNT_W = 16;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int DIV_W = 6;
  localparam int CLK_PERIOD_NS = 100;

  // ----------------------------------------------------------------
  // register byte offsets and word indices
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INTC = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_CON = 8'h08;
  localparam logic [7:0] OFF_CNT1 = 8'h0C;
  localparam logic [7:0] OFF_CNT2 = 8'h10;
  localparam logic [7:0] OFF_CNT3 = 8'h14;
  localparam logic [7:0] OFF_CNT4 = 8'h18;
  localparam logic [7:0] OFF_CLKDIV = 8'h1C;
  localparam logic [ADDR_W-1:0] IDX_INTC = OFF_INTC[5:2];
  localparam logic [ADDR_W-1:0] IDX_STAT = OFF_STAT[5:2];
  localparam logic [ADDR_W-1:0] IDX_CON = OFF_CON[5:2];
  localparam logic [ADDR_W-1:0] IDX_CNT1 = OFF_CNT1[5:2];
  localparam logic [ADDR_W-1:0] IDX_CNT2 = OFF_CNT2[5:2];
  localparam logic [ADDR_W-1:0] IDX_CNT3 = OFF_CNT3[5:2];
  localparam logic [ADDR_W-1:0] IDX_CNT4 = OFF_CNT4[5:2];
  localparam logic [ADDR_W-1:0] IDX_CLKDIV = OFF_CLKDIV[5:2];

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] INTC_RST = 8'h0F;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] CON_RST = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RST = 6'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam int INTC_MODE_ANY = 4;
  localparam int INTC_MODE_ALL = 5;
  localparam int INTC_MODE_FIRST = 6;
  localparam int INTC_MODE_SECOND = 7;
  localparam int CON_DCHG_LSB = 4;
  localparam int STAT_REQ_LSB = 4;

  // ----------------------------------------------------------------
  // channel state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CH_CLEAR = 4'b0001,
    CH_RUN = 4'b0010,
    CH_STOP = 4'b0100,
    CH_DONE = 4'b1000
  } qsj_chan_e;

endpackage

// ---- inc/qsj_chan_if.sv ----
/*
  per-channel link between the register core and one converter channel.
  assumes: one instance per channel, all on the system clock.
*/
`timescale 1ns/1ps
interface qsj_chan_if;
  import qsj_pkg::*;
  logic en;
  logic dchg;
  logic tick;
  logic comp;
  logic rd;
  logic [CNT_W-1:0] count;
  logic stop;

  modport ctrl (output en, output dchg, output tick, output comp, output rd,
                input count, input stop);
  modport chan (input en, input dchg, input tick, input comp, input rd,
                output count, output stop);
endinterface

// ---- core/qsj_channel.sv ----
/*
  one converter channel: a 16-bit ramp-time counter with stop flag.
  assumes: tick is a one-cycle pulse of the divided counting clock; comp is
  the synchronous comparator output, high once the ramp passes threshold.
*/
`timescale 1ns/1ps
module qsj_channel
(
  input wire logic i_sys_clk,  // system clock
  input wire logic i_rstn,     // async reset, active low
  qsj_chan_if.chan ch          // control and results
);
  import qsj_pkg::*;

  qsj_chan_e state_q;
  logic [CNT_W-1:0] count_q;

  // ----------------------------------------------------------------
  // channel sequence
  // ----------------------------------------------------------------
  // stop on threshold
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      state_q <= CH_CLEAR;
    else
    begin
      case (state_q)
        CH_CLEAR:
          if (ch.en && !ch.dchg)
            state_q <= CH_RUN;
        CH_RUN:
          if (!ch.en)
            state_q <= CH_CLEAR;
          else if (ch.comp)
            state_q <= CH_STOP;
        CH_STOP:
          if (!ch.en)
            state_q <= CH_CLEAR;
          else if (ch.rd)
            state_q <= CH_DONE;
        CH_DONE:
          if (!ch.en)
            state_q <= CH_CLEAR;
        default:
          state_q <= CH_CLEAR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // count from release
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      count_q <= CNT_RST;
    else if (state_q == CH_CLEAR || state_q == CH_DONE || !ch.en)
      count_q <= CNT_RST;
    else if (state_q == CH_STOP && ch.rd)
      count_q <= CNT_RST;
    else if (state_q == CH_RUN && !ch.comp && !ch.dchg && ch.tick)
      count_q <= count_q + 16'h0001;
  end

  assign ch.count = count_q;
  assign ch.stop = (state_q == CH_STOP);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_count_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ch.stop && ch.en && !ch.rd |=> ch.stop && $stable(count_q))
    else $error("stopped count changed before read");
  a_stop_on_comp: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    state_q == CH_RUN && ch.en && ch.comp |=> ch.stop ##0 count_q == $past(count_q))
    else $error("threshold did not stop channel");
  a_read_resets: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ch.stop && ch.en && ch.rd |=> !ch.stop && count_q == CNT_RST)
    else $error("read of stopped channel did not reset it");
  a_clear_count: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !ch.en |=> count_q == CNT_RST && !ch.stop)
    else $error("clear bit did not clear channel");
  c_channel_stop: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    state_q == CH_RUN ##1 ch.stop ##[1:20] ch.rd);
endmodule

// ---- core/qsj_joystick_top.sv ----
/*
  four-channel slope converter controller with strobe-timed register port.
  assumes: all inputs synchronous to i_sys_clk, including the free-running
  reference clock, which is sampled and divided; a select cycle precedes
  each read strobe so read data is registered before the strobe.
*/
`timescale 1ns/1ps
// Function
// - four channels, each 16-bit counter
// - count while converting, stop on threshold
// - hold stopped count until read, then reset
// - active-low discharge output per channel
// - bias enable is OR of enables
// - four channel enables, reset 0x0F
// - bits 7:4 select interrupt combination
// - request equals stop AND enable
// - status: requests high, stops low, read-only
// - control: discharge high nibble, counter enables low
// - counting starts together with ramp release
// - four read-only count registers, reset zero
// - counting clock is reference over twice divisor
// - interrupt high when selected combination requests
module qsj_joystick_top
#(
  parameter int NUM_CH = qsj_pkg::NCH  // channel count
)
(
  input wire logic i_sys_clk,                          // system clock, 10 MHz
  input wire logic i_rstn,                             // async reset, active low
  input wire logic i_psel,                             // peripheral select
  input wire logic i_pstb,                             // transfer strobe
  input wire logic i_pwrite,                           // 1 write, 0 read
  input wire logic [qsj_pkg::ADDR_W-1:0] i_pa,         // word address 5:2
  input wire logic [qsj_pkg::DATA_W-1:0] i_pd_in,      // data bus in
  output logic [qsj_pkg::DATA_W-1:0] o_pd_out,         // data bus out
  output logic o_pd_oe,                                // data bus drive enable
  input wire logic [NUM_CH-1:0] i_comp_trip,           // comparator outputs
  input wire logic i_reference_clock_in,               // free-running ref clock
  output logic [NUM_CH-1:0] o_ramp_dchg_n,             // discharge, active low
  output logic o_comparator_bias_enable,               // comparator bias on
  output logic o_threshold_irq                         // interrupt, active high
);
  import qsj_pkg::*;

  logic [7:0] intc_q;
  logic [7:0] con_q;
  logic [DIV_W-1:0] divide_setting_q;
  logic [DATA_W-1:0] rdata_q;
  logic pstb_q;
  logic ref_q;
  logic [DIV_W-1:0] div_cnt_q;
  logic div_phase_q;
  logic tick_q;
  logic irq_q;
  logic ref_rise;
  logic tick_d;
  logic wr_en;
  logic rd_pulse;
  logic [NUM_CH-1:0] cnt_sel;
  logic [NUM_CH-1:0] channel_irq_enable;
  logic [NUM_CH-1:0] stop_flags;
  logic [NUM_CH-1:0] req;
  logic [7:0] status;
  logic [CNT_W-1:0] count_value [NUM_CH];
  logic irq_d;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  function automatic logic [NUM_CH-1:0] cnt_hit(input logic [ADDR_W-1:0] a);
    logic [NUM_CH-1:0] h;
    h = '0;
    for (int k = 0; k < NUM_CH; k++)
      h[k] = (a == IDX_CNT1 + ADDR_W'(k));
    return h;
  endfunction

  assign wr_en = i_psel && i_pstb && i_pwrite;
  assign rd_pulse = i_psel && i_pstb && !i_pwrite && !pstb_q;
  assign o_pd_oe = i_psel && i_pstb && !i_pwrite;
  assign o_pd_out = rdata_q;
  assign cnt_sel = cnt_hit(i_pa);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pstb_q <= 1'b0;
    else
      pstb_q <= i_pstb;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      intc_q <= INTC_RST;
    else if (wr_en && i_pa == IDX_INTC)
      intc_q <= i_pd_in[7:0];
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      con_q <= CON_RST;
    else if (wr_en && i_pa == IDX_CON)
      con_q <= i_pd_in[7:0];
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      divide_setting_q <= DIV_RST;
    else if (wr_en && i_pa == IDX_CLKDIV)
      divide_setting_q <= i_pd_in[DIV_W-1:0];
  end

  assign status = {req, stop_flags};

  // read data captured before the strobe and held through it
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rdata_q <= '0;
    else if (i_psel && !i_pwrite && !i_pstb)
    begin
      rdata_q <= '0;
      case (i_pa)
        IDX_INTC:
          rdata_q <= {8'h00, intc_q};
        IDX_STAT:
          rdata_q <= {8'h00, status};
        IDX_CON:
          rdata_q <= {8'h00, con_q};
        IDX_CLKDIV:
          rdata_q <= {10'h000, divide_setting_q};
        default:
          for (int k = 0; k < NUM_CH; k++)
            if (cnt_sel[k])
              rdata_q <= count_value[k];
      endcase
    end
  end

  // ----------------------------------------------------------------
  // counting clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ref_q <= 1'b0;
    else
      ref_q <= i_reference_clock_in;
  end

  assign ref_rise = i_reference_clock_in && !ref_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_cnt_q <= '0;
      div_phase_q <= 1'b0;
    end
    else if (divide_setting_q == DIV_RST)
    begin
      div_cnt_q <= '0;
      div_phase_q <= 1'b0;
    end
    else if (ref_rise)
    begin
      if (div_cnt_q == divide_setting_q - 6'h01)
      begin
        div_cnt_q <= '0;
        div_phase_q <= !div_phase_q;
      end
      else
        div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  assign tick_d = ref_rise && (divide_setting_q != DIV_RST) && !div_phase_q &&
                  (div_cnt_q == divide_setting_q - 6'h01);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      tick_q <= 1'b0;
    else
      tick_q <= tick_d;
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  assign channel_irq_enable = intc_q[NUM_CH-1:0];
  assign o_comparator_bias_enable = |channel_irq_enable;
  assign o_ramp_dchg_n = ~con_q[CON_DCHG_LSB +: NUM_CH];

  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
      qsj_chan_if chif ();
      assign chif.en = con_q[g];
      assign chif.dchg = con_q[CON_DCHG_LSB + g];
      assign chif.tick = tick_q;
      assign chif.comp = i_comp_trip[g];
      assign chif.rd = rd_pulse && cnt_sel[g];
      assign count_value[g] = chif.count;
      assign stop_flags[g] = chif.stop;
      qsj_channel u_ch (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .ch(chif)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt combination
  // ----------------------------------------------------------------
  // request per channel
  assign req = stop_flags & channel_irq_enable;

  // mode select, pairs 1-2 and 3-4
  always_comb
  begin
    irq_d = 1'b0;
    if (intc_q[INTC_MODE_ANY] && |req)
      irq_d = 1'b1;
    if (intc_q[INTC_MODE_ALL] && |channel_irq_enable && req == channel_irq_enable)
      irq_d = 1'b1;
    if (intc_q[INTC_MODE_FIRST] && &req[1:0])
      irq_d = 1'b1;
    if (intc_q[INTC_MODE_SECOND] && &req[3:2])
      irq_d = 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign o_threshold_irq = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_bias_or_en: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_comparator_bias_enable == |intc_q[3:0])
    else $error("bias enable not OR of enables");
  a_intc_write: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wr_en && i_pa == IDX_INTC |=> intc_q == $past(i_pd_in[7:0]))
    else $error("interrupt control not written");
  a_status_map: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_psel && !i_pwrite && !i_pstb && i_pa == IDX_STAT
    |=> rdata_q[7:0] == {$past(stop_flags & intc_q[3:0]), $past(stop_flags)})
    else $error("status read data wrong");
  a_dchg_pins: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wr_en && i_pa == IDX_CON |=> o_ramp_dchg_n == ~$past(i_pd_in[7:4]))
    else $error("discharge pins do not follow control");
  a_div_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    divide_setting_q == DIV_RST |=> !tick_q)
    else $error("tick with zero divisor");
  a_tick_on_rise: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    tick_q |-> $past(ref_rise) && !$past(div_phase_q) && div_phase_q)
    else $error("tick not on divided clock rise");
  a_irq_any: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    intc_q[INTC_MODE_ANY] && |(stop_flags & intc_q[3:0]) |=> o_threshold_irq)
    else $error("any-mode interrupt missing");
  a_irq_pair: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    intc_q[7:4] == 4'h4 && !(&(stop_flags[1:0] & intc_q[1:0])) |=> !o_threshold_irq)
    else $error("first-pair interrupt without both requests");
  a_reads_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    i_psel && !i_pwrite && !i_pstb && i_pa > IDX_CLKDIV |=> rdata_q == '0)
    else $error("unmapped read not zero");
  c_irq_raised: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !o_threshold_irq ##1 o_threshold_irq);
  c_all_mode: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    intc_q[INTC_MODE_ALL] && o_threshold_irq);
  c_count_read: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    rd_pulse && |(cnt_hit(i_pa) & stop_flags));
endmodule

// ---- tb/qsj_bridge_model.sv ----
/*
  bus master model for the register port: select, strobe, direction, index.
  assumes: tasks are entered one step after a rising edge of i_sys_clk.
*/
`timescale 1ns/1ps
module qsj_bridge_model
(
  input wire logic i_sys_clk,                      // system clock
  input wire logic [qsj_pkg::DATA_W-1:0] i_pd_out, // read data from block
  input wire logic i_pd_oe,                        // block drives data bus
  output logic o_psel,                             // peripheral select
  output logic o_pstb,                             // transfer strobe
  output logic o_pwrite,                           // 1 write, 0 read
  output logic [qsj_pkg::ADDR_W-1:0] o_pa,         // word index
  output logic [qsj_pkg::DATA_W-1:0] o_pd_in       // write data
);
  import qsj_pkg::*;

  initial
  begin
    o_psel = 1'b0;
    o_pstb = 1'b0;
    o_pwrite = 1'b0;
    o_pa = 4'h0;
    o_pd_in = 16'h0000;
  end

  // ----------------------------------------------------------------
  // transfers
  // ----------------------------------------------------------------
  // select, index, direction
  task automatic wr(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] d);
    o_psel = 1'b1;
    o_pstb = 1'b1;
    o_pwrite = 1'b1;
    o_pa = idx;
    o_pd_in = d;
    @(posedge i_sys_clk);
    #1;
    o_psel = 1'b0;
    o_pstb = 1'b0;
    // released bus must not keep showing the last value
    o_pd_in = ~d;
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] idx, output logic [DATA_W-1:0] d,
                    output logic oe);
    o_psel = 1'b1;
    o_pwrite = 1'b0;
    o_pa = idx;
    @(posedge i_sys_clk);
    #1;
    o_pstb = 1'b1;
    @(posedge i_sys_clk);
    d = i_pd_out;
    oe = i_pd_oe;
    #1;
    o_psel = 1'b0;
    o_pstb = 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask
endmodule

// ---- tb/qsj_joystick_top_test.sv ----
/*
  self-checking bench for the four-channel slope converter controller.
  assumes: bus master model drives the register port; comparators are
  driven directly by the bench; reference clock is a quarter of sys clock.
*/
`timescale 1ns/1ps
module qsj_joystick_top_test;
  import qsj_pkg::*;

  logic sys_clk;
  logic rstn;
  logic psel;
  logic pstb;
  logic pwrite;
  logic [ADDR_W-1:0] pa;
  logic [DATA_W-1:0] pd_in;
  logic [DATA_W-1:0] pd_out;
  logic pd_oe;
  logic [NCH-1:0] comp;
  logic ref_clk;
  logic [NCH-1:0] dchg_n;
  logic bias_en;
  logic irq;
  int err_count = 0;
  int checks = 0;

  // ----------------------------------------------------------------
  // clocks and instances
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    ref_clk = 1'b0;
    forever
    begin
      repeat (2) @(posedge sys_clk);
      #1 ref_clk = ~ref_clk;
    end
  end

  qsj_joystick_top u_dut (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_psel(psel), .i_pstb(pstb),
    .i_pwrite(pwrite), .i_pa(pa), .i_pd_in(pd_in), .o_pd_out(pd_out), .o_pd_oe(pd_oe),
    .i_comp_trip(comp), .i_reference_clock_in(ref_clk), .o_ramp_dchg_n(dchg_n),
    .o_comparator_bias_enable(bias_en), .o_threshold_irq(irq));

  qsj_bridge_model u_bridge (.i_sys_clk(sys_clk), .i_pd_out(pd_out), .i_pd_oe(pd_oe),
    .o_psel(psel), .o_pstb(pstb), .o_pwrite(pwrite), .o_pa(pa), .o_pd_in(pd_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [DATA_W-1:0] got, input int lo, input int hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t count %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    logic oe;
    u_bridge.rd(idx, d, oe);
    chk(d, exp);
    chk({15'h0000, oe}, 16'h0001);
  endtask

  task automatic wrd(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] w,
                     input logic [DATA_W-1:0] exp);
    u_bridge.wr(idx, w);
    rdchk(idx, exp);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 9; i++)
      rdchk(i[3:0], (i == 0) ? 16'h000F : 16'h0000);
    chk({12'h000, dchg_n}, 16'h000F);
    chk({15'h0000, bias_en}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
  endtask

  task automatic t_access();
    wrd(IDX_INTC, 16'h00A5, 16'h00A5);
    wrd(IDX_STAT, 16'h00FF, 16'h0000);
    wrd(IDX_CON, 16'h00A0, 16'h00A0);
    chk({12'h000, dchg_n}, 16'h0005);
    wrd(IDX_CNT1, 16'h1234, 16'h0000);
    wrd(IDX_CLKDIV, 16'h003F, 16'h003F);
    wrd(IDX_INTC, 16'h0000, 16'h0000);
    chk({15'h0000, bias_en}, 16'h0000);
    u_bridge.wr(IDX_INTC, 16'h000F);
    u_bridge.wr(IDX_CON, 16'h0000);
  endtask

  task automatic t_convert(input int k, input int dv);
    int lo;
    int hi;
    lo = (dv == 0) ? 0 : 80 / (8 * dv) - 1;
    hi = (dv == 0) ? 0 : 84 / (8 * dv) + 1;
    u_bridge.wr(IDX_CLKDIV, 16'(dv));
    u_bridge.wr(IDX_CON, 16'h0001 << (4 + k));
    chk({12'h000, dchg_n}, {12'h000, ~(4'h1 << k)});
    u_bridge.wr(IDX_CON, 16'h0001 << k);
    cyc(80);
    comp[k] = 1'b1;
    cyc(20);
    // count read only after stop seen
    rdchk(IDX_STAT, (16'h0011 << k));
    chk({15'h0000, irq}, 16'h0000);
    begin
      logic [DATA_W-1:0] d;
      logic oe;
      u_bridge.rd(IDX_CNT1 + 4'(k), d, oe);
      chk_rng(d, lo, hi);
    end
    rdchk(IDX_CNT1 + 4'(k), 16'h0000);
    rdchk(IDX_STAT, 16'h0000);
    comp[k] = 1'b0;
    u_bridge.wr(IDX_CON, 16'h0000);
  endtask

  task automatic t_modes();
    logic [3:0] ex;
    u_bridge.wr(IDX_CLKDIV, 16'h0001);
    u_bridge.wr(IDX_CON, 16'h00F0);
    u_bridge.wr(IDX_CON, 16'h000F);
    cyc(20);
    for (int p = 0; p < 2; p++)
    begin
      comp = (p == 0) ? 4'h3 : 4'hF;
      ex = (p == 0) ? 4'h5 : 4'hF;
      cyc(3);
      for (int m = 4; m < 8; m++)
      begin
        u_bridge.wr(IDX_INTC, 16'h000F | (16'h0001 << m));
        cyc(2);
        chk({15'h0000, irq}, {15'h0000, ex[m-4]});
      end
    end
    wrd(IDX_INTC, 16'h0011, 16'h0011);
    rdchk(IDX_STAT, 16'h001F);
    chk({15'h0000, irq}, 16'h0001);
    u_bridge.wr(IDX_INTC, 16'h0041);
    cyc(2);
    chk({15'h0000, irq}, 16'h0000);
    comp = 4'h0;
    u_bridge.wr(IDX_CON, 16'h0000);
    u_bridge.wr(IDX_INTC, 16'h000F);
    rdchk(IDX_STAT, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    comp = 4'h0;
    repeat (3) @(posedge sys_clk);
    #1 rstn = 1'b1;
    cyc(1);
    t_reset();
    t_access();
    t_convert(0, 0);
    for (int k = 0; k < NCH; k++)
      t_convert(k, k + 1);
    t_modes();
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("[ERR] %0t run did not finish", $time);
    close_out();
  end
endmodule
